//--- hw/sync_2ff.sv
/*
  Two flip-flop synchroniser for a group of independent level signals.
  Assumes each bit is a slow level from outside the sys_clk domain; only
  the second stage is visible to the rest of the design.
*/
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("sync_2ff needs WIDTH of at least one");
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      stageOne <= INIT;
      syncOut <= INIT;
    end
    else if (clkEnable)
    begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end

endmodule

//--- hw/watchdog_timer.sv
/*
  Watchdog timer on a low-speed RC clock with an AXI4-Lite register slave.
  Assumes the RC clock and the reset pin and power-on/low-voltage request
  arrive asynchronously, and the standby level comes from the CPU on sys_clk.
*/
`timescale 1ns/10ps
module watchdog_timer #(
  parameter int ADDR_WIDTH = 18
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic rcClkIn,
  input wire logic externalResetPinN,
  input wire logic lowVoltageDetectReset,
  input wire logic standby,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic watchdogReset,
  output logic rcOscEnable
);

  // ************************************************************
  // Elaboration checks and helpers
  // ************************************************************
  initial
  begin
    if (ADDR_WIDTH < wdt_pkg::MIN_ADDR_WIDTH)
      $error("watchdog_timer needs ADDR_WIDTH of at least 18");
  end

  // Overflow threshold for a select code
  function automatic logic [16:0] thresholdOf(input logic [2:0] sel);
    thresholdOf = wdt_pkg::BASE_THRESHOLD << sel;
  endfunction

  // Address match against a package byte address
  function automatic logic addrIs(input logic [ADDR_WIDTH-1:0] addr, input logic [17:0] target);
    addrIs = (addr == ADDR_WIDTH'(target));
  endfunction

  // ************************************************************
  // State declarations
  // ************************************************************
  logic [7:0] watchdog_control;
  logic [7:0] next_watchdog_control;
  logic [wdt_pkg::COUNT_WIDTH-1:0] watchdog_counter;
  logic [wdt_pkg::COUNT_WIDTH-1:0] next_watchdog_counter;
  logic [ADDR_WIDTH-1:0] awAddrHeld;
  logic [7:0] wDataHeld;
  logic wStrbLowHeld;
  logic [2:0] syncedIn;
  logic rcLevelPrev;
  logic standbyPrev;
  logic [2:0] periodsSinceExit;
  logic keepOscInStandby;

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  // RC clock, reset pin and low-voltage request enter through two flops
  // synchronise crossings
  sync_2ff #(.WIDTH(3), .INIT(3'h2)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .asyncIn({lowVoltageDetectReset, externalResetPinN, rcClkIn}),
    .syncOut(syncedIn)
  );

  // Decoded synchronised inputs
  wire rcLevelNow = syncedIn[0];
  wire pinResetActive = ~syncedIn[1];
  wire lvdResetActive = syncedIn[2];
  wire hardReset = pinResetActive | lvdResetActive;
  // One RC period seen, from the second synchroniser stage onward
  wire rcTick = rcLevelNow & ~rcLevelPrev;

  // ************************************************************
  // Control field decoding
  // ************************************************************
  wire runBit = watchdog_control[wdt_pkg::RUN_BIT];
  wire [1:0] standbyMode = watchdog_control[wdt_pkg::STBY_HI_BIT:wdt_pkg::STBY_LO_BIT];
  wire [2:0] thresholdSel = watchdog_control[wdt_pkg::SEL_HI_BIT:wdt_pkg::SEL_LO_BIT];
  wire modeContinue = (standbyMode == wdt_pkg::STBY_CONTINUE_A) |
                      (standbyMode == wdt_pkg::STBY_CONTINUE_B);
  wire modeStop = (standbyMode == wdt_pkg::STBY_STOP);
  wire modeHold = (standbyMode == wdt_pkg::STBY_HOLD);

  // ************************************************************
  // Standby tracking
  // ************************************************************
  // standby level from the CPU
  wire standbyEntry = standby & ~standbyPrev;
  wire standbyExit = ~standby & standbyPrev;
  wire guardElapsed = (periodsSinceExit >= wdt_pkg::HOLD_GUARD_PERIODS);

  // Standby edges and RC periods counted since the last exit
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      standbyPrev <= 1'b0;
      rcLevelPrev <= 1'b0;
      periodsSinceExit <= wdt_pkg::HOLD_GUARD_PERIODS;
    end
    else if (clkEnable)
    begin
      standbyPrev <= standby;
      rcLevelPrev <= rcLevelNow;
      if (standbyExit)
        periodsSinceExit <= 3'h0;
      else if (rcTick && !standby && !guardElapsed)
        periodsSinceExit <= periodsSinceExit + 3'h1;
    end
  end

  // Oscillator kept alive through a hold-mode standby entered too soon after exit
  // early re-entry in hold mode keeps oscillator
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      keepOscInStandby <= 1'b0;
    else if (clkEnable)
    begin
      if (standbyEntry)
        keepOscInStandby <= modeHold & ~guardElapsed;
      else if (standbyExit)
        keepOscInStandby <= 1'b0;
    end
  end

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  // Write performed once address and data are both held
  wire awTaken = s_axi_awvalid & s_axi_awready;
  wire wTaken = s_axi_wvalid & s_axi_wready;
  wire doWrite = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wrCtrlAddr = addrIs(awAddrHeld, wdt_pkg::CTRL_ADDR);
  wire wrServiceAddr = addrIs(awAddrHeld, wdt_pkg::SERVICE_ADDR);
  wire wrMapped = wrCtrlAddr | wrServiceAddr | addrIs(awAddrHeld, wdt_pkg::COUNT_ADDR);
  wire wrCtrl = doWrite & wrCtrlAddr & wStrbLowHeld;
  wire wrCtrlAllowed = wrCtrl & ~runBit;
  // only the key register restarts; control writes never do
  wire serviceClear = doWrite & wrServiceAddr & wStrbLowHeld & runBit &
                      (wDataHeld == wdt_pkg::RESTART_KEY);

  // Address and data capture, each in its own order
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      awAddrHeld <= '0;
      wDataHeld <= 8'h00;
      wStrbLowHeld <= 1'b0;
    end
    else if (clkEnable)
    begin
      if (awTaken)
        awAddrHeld <= s_axi_awaddr;
      if (wTaken)
      begin
        wDataHeld <= s_axi_wdata[7:0];
        wStrbLowHeld <= s_axi_wstrb[0];
      end
    end
  end

  // Handshake and response for one write at a time
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wdt_pkg::RESP_OKAY;
    end
    else if (clkEnable)
    begin
      if (awTaken)
        s_axi_awready <= 1'b0;
      if (wTaken)
        s_axi_wready <= 1'b0;
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  // Read data selected from live state at the address handshake
  wire arTaken = s_axi_arvalid & s_axi_arready;
  wire rdCtrl = addrIs(s_axi_araddr, wdt_pkg::CTRL_ADDR);
  wire rdCount = addrIs(s_axi_araddr, wdt_pkg::COUNT_ADDR);
  wire rdMapped = rdCtrl | rdCount | addrIs(s_axi_araddr, wdt_pkg::SERVICE_ADDR);
  wire [31:0] rdData = rdCtrl ? {24'h000000, watchdog_control} :
                       rdCount ? {16'h0000, watchdog_counter} : 32'h00000000;

  // One read at a time, data registered with the response
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= wdt_pkg::RESP_OKAY;
    end
    else if (clkEnable)
    begin
      if (arTaken)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdMapped ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  // count only while run bit is one
  // hold and stop modes freeze counting in standby
  wire countEnable = runBit & (~standby | modeContinue);
  wire countTick = rcTick & countEnable;
  wire [16:0] countPlusOne = {1'b0, watchdog_counter} + 17'h00001;
  // overflow at threshold, a restart in the same cycle wins
  wire overflow = countTick & ~serviceClear & ~hardReset &
                  (countPlusOne == thresholdOf(thresholdSel));
  wire stopEntry = standbyEntry & modeStop;

  // Next count, cleared on stop, restart, overflow or hard reset
  always_comb
  begin
    next_watchdog_counter = watchdog_counter;
    if (!runBit || hardReset || overflow || stopEntry || serviceClear)
      next_watchdog_counter = '0;
    else if (countTick)
      next_watchdog_counter = countPlusOne[15:0];
  end

  // ************************************************************
  // Control register
  // ************************************************************
  // Next control value: write, then overflow effects, then hard reset
  always_comb
  begin
    next_watchdog_control = watchdog_control;
    if (wrCtrlAllowed)
      next_watchdog_control = wDataHeld;
    // overflow sets the flag, winning over a clearing write
    // bits 4 down to 0 left as they were
    if (overflow)
    begin
      next_watchdog_control[wdt_pkg::FLAG_BIT] = 1'b1;
      next_watchdog_control[wdt_pkg::RUN_BIT] = 1'b0;
    end
    if (hardReset)
      next_watchdog_control = wdt_pkg::CTRL_RESET;
  end

  // Counter and control storage
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      watchdog_control <= wdt_pkg::CTRL_RESET;
      watchdog_counter <= '0;
    end
    else if (clkEnable)
    begin
      watchdog_control <= next_watchdog_control;
      watchdog_counter <= next_watchdog_counter;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // oscillator follows run bit
  // off in hold or stop standby unless kept alive
  wire oscStandbyOff = standby & (modeHold | modeStop) & ~keepOscInStandby;
  wire next_rcOscEnable = next_watchdog_control[wdt_pkg::RUN_BIT] & ~oscStandbyOff;

  // Registered reset pulse and oscillator enable
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      watchdogReset <= 1'b0;
      rcOscEnable <= 1'b0;
    end
    else if (clkEnable)
    begin
      watchdogReset <= overflow;
      rcOscEnable <= next_rcOscEnable;
    end
  end

endmodule

//--- hw/wdt_pkg.sv
/*
  Constants shared by the watchdog block: register byte addresses, field
  positions, reset values, standby behaviour codes and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus and an 8-bit control register.
*/
package wdt_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  // Printed control offset is not word aligned, so it is an index
  localparam logic [17:0] CTRL_INDEX = 18'h0fe79;
  localparam logic [17:0] CTRL_ADDR = {CTRL_INDEX[15:0], 2'b00};
  // Restart key register, accepts the qualified 55h write
  localparam logic [17:0] SERVICE_ADDR = 18'h3f9e8;
  // Read-only view of the running count
  localparam logic [17:0] COUNT_ADDR = 18'h3f9ec;
  localparam int MIN_ADDR_WIDTH = 18;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int FLAG_BIT = 7;
  localparam int TEST_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int STBY_HI_BIT = 4;
  localparam int STBY_LO_BIT = 3;
  localparam int SEL_HI_BIT = 2;
  localparam int SEL_LO_BIT = 0;
  localparam int KEEP_HI_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RESTART_KEY = 8'h55;

  // ************************************************************
  // Standby behaviour codes
  // ************************************************************
  localparam logic [1:0] STBY_CONTINUE_A = 2'h0;
  localparam logic [1:0] STBY_STOP = 2'h1;
  localparam logic [1:0] STBY_HOLD = 2'h2;
  localparam logic [1:0] STBY_CONTINUE_B = 2'h3;

  // ************************************************************
  // Counter and timing
  // ************************************************************
  localparam int COUNT_WIDTH = 16;
  // Smallest overflow threshold, doubled per select step
  localparam logic [16:0] BASE_THRESHOLD = 17'h00200;
  // RC periods needed after standby exit before a hold-mode standby may stop the oscillator
  localparam logic [2:0] HOLD_GUARD_PERIODS = 3'h4;

  // ************************************************************
  // AXI4-Lite responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- tb/rc_osc_model.sv
/*
  Behavioural low-speed RC oscillator feeding the watchdog tick input.
  Assumes the enable comes from the block's oscillator enable output.
*/
`timescale 1ns/10ps
module rc_osc_model #(
  parameter realtime HALF = 41.5
) (
  input wire logic enable,
  output logic rcClk
);
  // ************************************************************
  // Oscillation
  // ************************************************************
  // runs only enabled; idles low between runs
  initial
  begin
    rcClk = 1'b0;
    forever
    begin
      wait (enable);
      #HALF rcClk = 1'b1;
      #HALF rcClk = 1'b0;
    end
  end
endmodule

//--- tb/watchdog_timer_rc_clocked_tb_top.sv
/*
  Self-checking bench for the watchdog block: register table, overflow,
  lock and restart, hard resets and the standby behaviours.
  Assumes the package constants and an RC oscillator model.
*/
`timescale 1ns/10ps
module watchdog_timer_rc_clocked_tb_top;
  typedef struct packed
  {
    logic [17:0] addr;
    logic [7:0] wdata;
    logic [1:0] bresp;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } row_t;
  logic sys_clk, reset, rcClkIn, externalResetPinN, lowVoltageDetectReset, standby;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, a, b, c;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, wdRst, oscEn, ce;
  logic [3:0] strb;
  logic [1:0] bresp, rresp, r;
  int error_cnt, checks, n;
  // Rows: write then read back
  // test bit zero
  row_t rows [5] = '{
    '{wdt_pkg::CTRL_ADDR, 8'h1b, 2'h0, 8'h1b, 2'h0},
    '{wdt_pkg::CTRL_ADDR, 8'h80, 2'h0, 8'h80, 2'h0},
    '{wdt_pkg::CTRL_ADDR, 8'h00, 2'h0, 8'h00, 2'h0},
    '{wdt_pkg::COUNT_ADDR, 8'h12, 2'h0, 8'h00, 2'h0},
    '{18'h3f9f0, 8'h12, 2'h2, 8'h00, 2'h2}};

  // ************************************************************
  // Design, oscillator and clock
  // ************************************************************
  watchdog_timer #(.ADDR_WIDTH(18)) i_dut (.sys_clk(sys_clk), .reset(reset),
    .clkEnable(ce), .rcClkIn(rcClkIn), .externalResetPinN(externalResetPinN),
    .lowVoltageDetectReset(lowVoltageDetectReset), .standby(standby),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .watchdogReset(wdRst),
    .rcOscEnable(oscEn));
  rc_osc_model i_osc (.enable(oscEn), .rcClk(rcClkIn));
  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus write; response accepted one cycle after it shows
  task automatic axw(input logic [17:0] ad, input logic [7:0] d);
    awaddr <= ad;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (bvalid) bready <= 1'b1;
    end
  endtask
  // Bus read; data accepted one cycle after it shows
  task automatic axr(input logic [17:0] ad, output logic [31:0] d);
    araddr <= ad;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (rvalid) rready <= 1'b1;
    end
  endtask
  // Hard reset from the pin or the low-voltage detector
  task automatic hrst(input bit pin);
    if (pin) externalResetPinN <= 1'b0;
    else lowVoltageDetectReset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    externalResetPinN <= 1'b1;
    lowVoltageDetectReset <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task summarize;
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Stimulus
  // ************************************************************
  // Watchdog on a hung run
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, standby, lowVoltageDetectReset} = '0;
    {awaddr, araddr, wdata} = '0;
    externalResetPinN = 1'b1;
    ce = 1'b1;
    strb = 4'hf;
    reset = 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    axr(wdt_pkg::CTRL_ADDR, a);
    chk("ctrl_reset", a, 32'h0);
    foreach (rows[i])
    begin
      axw(rows[i].addr, rows[i].wdata);
      chk("bresp", 32'(r), 32'(rows[i].bresp));
      axr(rows[i].addr, a);
      chk("rdata", a, 32'(rows[i].rdata));
      chk("rresp", 32'(r), 32'(rows[i].rresp));
    end
    // Overflow at 512 ticks of 83 ns, modes kept
    axw(wdt_pkg::CTRL_ADDR, 8'h38);
    chk("osc_on", 32'(oscEn), 32'h1);
    n = 0;
    while (wdRst !== 1'b1)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("ovf_time", 32'(n >= 4230 && n <= 4275), 32'h1);
    axr(wdt_pkg::CTRL_ADDR, a);
    chk("ctrl_ovf", a, 32'h98);
    hrst(1);
    axr(wdt_pkg::CTRL_ADDR, a);
    chk("ctrl_pin", a, 32'h0);
    // Lock, ignored 55h and restart key
    axw(wdt_pkg::CTRL_ADDR, 8'h21);
    repeat (2000) @(posedge sys_clk);
    axw(wdt_pkg::CTRL_ADDR, 8'h00);
    axr(wdt_pkg::COUNT_ADDR, a);
    chk("count_step", 32'(a > 220 && a < 260), 32'h1);
    axw(wdt_pkg::CTRL_ADDR, 8'h55);
    axr(wdt_pkg::COUNT_ADDR, b);
    chk("no_clear", 32'(b >= a), 32'h1);
    axr(wdt_pkg::CTRL_ADDR, c);
    chk("ctrl_locked", c, 32'h21);
    // Clock enable low freezes the count
    ce <= 1'b0;
    repeat (200) @(posedge sys_clk);
    ce <= 1'b1;
    axr(wdt_pkg::COUNT_ADDR, c);
    chk("ce_freeze", 32'(c - b < 3), 32'h1);
    axw(wdt_pkg::SERVICE_ADDR, 8'h55);
    axr(wdt_pkg::COUNT_ADDR, c);
    chk("restart", 32'(c < 4), 32'h1);
    // Each standby behaviour, fresh after a low-voltage reset
    for (int m = 0; m < 4; m++)
    begin
      hrst(0);
      axw(wdt_pkg::CTRL_ADDR, {3'b001, 2'(m), 3'b001});
      repeat (300) @(posedge sys_clk);
      standby <= 1'b1;
      repeat (100) @(posedge sys_clk);
      axr(wdt_pkg::COUNT_ADDR, a);
      repeat (1000) @(posedge sys_clk);
      axr(wdt_pkg::COUNT_ADDR, b);
      chk("stby_osc", 32'(oscEn), 32'(m == 0 || m == 3));
      if (m == 0 || m == 3)
        chk("stby_run", 32'(b > a), 32'h1);
      else
        chk("stby_count", b, m == 1 ? 32'h0 : a);
      standby <= 1'b0;
      repeat (500) @(posedge sys_clk);
      axr(wdt_pkg::COUNT_ADDR, c);
      chk("resume", 32'(c > b), 32'h1);
    end
    // Strobe-less control write is ignored
    hrst(0);
    strb <= 4'h0;
    axw(wdt_pkg::CTRL_ADDR, 8'h31);
    strb <= 4'hf;
    axr(wdt_pkg::CTRL_ADDR, a);
    chk("strb_off", a, 32'h0);
    axw(wdt_pkg::CTRL_ADDR, 8'h31);
    repeat (300) @(posedge sys_clk);
    standby <= 1'b1;
    repeat (100) @(posedge sys_clk);
    chk("hold_osc", 32'(oscEn), 32'h0);
    standby <= 1'b0;
    repeat (10) @(posedge sys_clk);
    standby <= 1'b1;
    axr(wdt_pkg::COUNT_ADDR, a);
    repeat (200) @(posedge sys_clk);
    axr(wdt_pkg::COUNT_ADDR, b);
    chk("keep_osc", 32'(oscEn), 32'h1);
    chk("keep_frozen", b, a);
    summarize();
  end
endmodule

//--- tb/wdt_checker_properties.sv
/*
  Port checker for the watchdog block.
  Assumes clkEnable only drops while the bus is idle and it is bound to
  watchdog_timer.
*/
`timescale 1ns/10ps
module wdt_checker #(
  parameter int ADDR_WIDTH = 18
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic externalResetPinN,
  input wire logic lowVoltageDetectReset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watchdogReset,
  input wire logic rcOscEnable
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Bus answers and holding
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[1:0] == 2'b00 && s_axi_araddr != wdt_pkg::CTRL_ADDR
    && s_axi_araddr != wdt_pkg::SERVICE_ADDR && s_axi_araddr != wdt_pkg::COUNT_ADDR
    |=> s_axi_rresp == wdt_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Reset and overflow effects on outputs
  a_reset_quiet: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid
    && !rcOscEnable && !watchdogReset) else $error("outputs active after reset");
  a_pin_clear: assert property (!externalResetPinN [*6] |-> !rcOscEnable)
    else $error("oscillator on during pin reset");
  a_lvd_clear: assert property (lowVoltageDetectReset [*6] |-> !rcOscEnable)
    else $error("oscillator on during low voltage reset");
  a_ovf_pulse: assert property (watchdogReset |=> !watchdogReset)
    else $error("overflow reset longer than one cycle");
  a_ovf_stops: assert property ($rose(watchdogReset) |-> ##[0:2] !rcOscEnable)
    else $error("run not cleared on overflow");
endmodule

bind watchdog_timer wdt_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.sys_clk(sys_clk),
  .reset(reset), .externalResetPinN(externalResetPinN),
  .lowVoltageDetectReset(lowVoltageDetectReset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .watchdogReset(watchdogReset),
  .rcOscEnable(rcOscEnable));
